//--- dat_cfg.svh
// Constants of the auxiliary timer, counter and reference block.
// Assumes a 10 MHz clock and word addresses on the register bus.
// Function
// - Uniform-reach output with range hysteresis.
// - Multi-pump: high and low speed thresholds.
// - Timer one 0.1-10 s, two 1-100 s; after reset timer two is 0 s until written.
// - Timer output after delay while started.
// - Start open clears time and output.
// - Count pulses, flag at counting value.
// - Recount only after clear; intermediate alike.
// - Trigger levels last at least 2 ms.
// - Counter stops at 65535.
// - Target on equal, intermediate on greater-equal.
// - Analog source chosen by code 0-10.
// - Stacked source gives half sum times 50 Hz.
// - Filter constant 0-50, larger is slower.
// - Linear map between two endpoint frequencies.
// - Endpoint direction bit: 1 means reverse.
// - Negative region reverses only when enabled.
// - Forbidden negative region commands 0 Hz.
// - External reverse command flips direction.
// - Retain 0 drops UP/DOWN change at stop.
// - Main frequency setting always kept.
// - UP/DOWN step 0.01 Hz or 0.1 Hz.
`ifndef DAT_CFG_SVH
`define DAT_CFG_SVH
`define DAT_CLK_HZ     32'h0098_9680
`define DAT_MS_CYC     (`DAT_CLK_HZ / 32'h0000_03E8)
`define DAT_PULSE_MS   32'h0000_0002
`define DAT_PULSE_CYC  (`DAT_MS_CYC * `DAT_PULSE_MS)
`define DAT_TICK_MS    7'h64
`define DAT_T1_MIN     16'h0001
`define DAT_T1_MAX     16'h0064
`define DAT_T2_MIN     16'h0001
`define DAT_T2_MAX     16'h0064
`define DAT_T2_SCALE   11'h00A
`define DAT_CNT_SET    16'hFFDC
`define DAT_CNT_SAT    16'hFFFF
`define DAT_FREQ_MAX   16'h9C40
`define DAT_RANGE_MAX  16'h03E8
`define DAT_FILT_MAX   16'h0032
`define DAT_SRC_MAX    16'h000A
`define DAT_STACK_FREQ 32'h0000_1388
`define DAT_I4MA       12'h333
`define DAT_STEP_FINE  18'h0_0001
`define DAT_STEP_COARSE 18'h0_000A
`define DAT_IX_UF1     5'h00
`define DAT_IX_UF2     5'h01
`define DAT_IX_RANGE   5'h02
`define DAT_IX_T1      5'h03
`define DAT_IX_T2      5'h04
`define DAT_IX_CTGT    5'h05
`define DAT_IX_CMID    5'h06
`define DAT_IX_SRC     5'h07
`define DAT_IX_FILT    5'h08
`define DAT_IX_LOF     5'h09
`define DAT_IX_LOD     5'h0A
`define DAT_IX_HIF     5'h0B
`define DAT_IX_HID     5'h0C
`define DAT_IX_NEGREV  5'h0D
`define DAT_IX_RETAIN  5'h0E
`define DAT_IX_STEP    5'h0F
`define DAT_IX_PROG    5'h10
`define DAT_IX_MAIN    5'h11
`define DAT_IX_STATUS  5'h12
`define DAT_IX_CTRL    5'h13
`define DAT_NREG       18
`define DAT_RST_RANGE  16'h0032
`define DAT_RST_T1     16'h0001
`define DAT_RST_FILT   16'h0014
`define DAT_RST_HIF    16'h1388
`define DAT_ST_TGT     16
`define DAT_ST_MID     17
`define DAT_ST_T1      18
`define DAT_ST_T2      19
`define DAT_ST_R1      20
`define DAT_ST_R2      21
`define DAT_ST_REV     22
`define DAT_CTRL_CLR   0
`endif

//--- dat_pkg.sv
// Types of the auxiliary timer, counter and reference block.
// Assumes dat_cfg.svh is on the include path.
`include "dat_cfg.svh"
package dat_pkg;
    typedef enum logic [3:0] {
        SRC_V10, SRC_V5, SRC_I20, SRC_I4, SRC_STACK, SRC_A,
        SRC_VA2, SRC_VA4, SRC_AB2, SRC_MAX, SRC_MIN
    } dat_src_t;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        lvl;
        logic [15:0] cnt;
    } dat_qual_t;

    typedef struct packed {
        logic [`DAT_NREG-1:0][15:0] cfg;
        logic               waitreq;
        logic [31:0]        rdata;
        logic               clr;
        logic [15:0]        ms_c;
        logic [6:0]         tick_c;
        logic               trig_q;
        logic [15:0]        count;
        logic               tgt;
        logic               mid;
        logic [10:0]        el1;
        logic [10:0]        el2;
        logic               t1;
        logic               t2;
        logic               r1;
        logic               r2;
        logic [11:0]        y;
        logic [5:0]         fc;
        logic [15:0]        af;
        logic               arev;
        logic               run_q;
        logic signed [17:0] off;
        logic [15:0]        sf;
    } dat_state_t;
endpackage

//--- dat_qual.sv
// Input synchroniser with a minimum stable-width qualifier.
// Assumes the input is an external level that may bounce.
`timescale 1ns/100ps
`default_nettype none
module dat_qual #(
    parameter int unsigned CYC = 1
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic in_i,
    output logic      level_o
);
    dat_pkg::dat_qual_t st;
    dat_pkg::dat_qual_t next_st;

    if (CYC < 1 || CYC > 65536) begin : g_chk
        $error("dat_qual: CYC out of range");
    end

    always_comb begin
        next_st = st;
        next_st.s1 = in_i;
        next_st.s2 = st.s1;
        // A level shorter than CYC cycles never reaches the output.
        if (st.s2 == st.lvl) begin
            next_st.cnt = 16'h0000;
        end else if (st.cnt == 16'(CYC - 1)) begin
            next_st.lvl = st.s2;
            next_st.cnt = 16'h0000;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.lvl;

    a_qual_width: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        $changed(st.lvl) |-> $past(st.cnt) == 16'(CYC - 1))
        else $error("level changed before the minimum width");
endmodule
`default_nettype wire

//--- dat_sw.sv
// Model of the external proximity switch that feeds the counter trigger.
// Assumes the bench calls its pulse task after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module dat_sw #(
    parameter int unsigned W = 30
) (
    input  wire logic clock_i,
    output logic      trig_o
);
    initial trig_o = 1'b0;
    // Each level is held for W cycles, above the qualify width.
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (W) @(posedge clock_i);
            trig_o <= 1'b1;
            repeat (W) @(posedge clock_i);
            trig_o <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- dat_top.sv
// Uniform-reach, timers, event counter, analog reference and UP/DOWN.
// Assumes word addresses on the Avalon-MM slave and synchronous inputs.
`timescale 1ns/100ps
`default_nettype none
`include "dat_cfg.svh"
module dat_top #(
    parameter int unsigned MS_CYC    = `DAT_MS_CYC,
    parameter int unsigned PULSE_CYC = `DAT_PULSE_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [15:0] out_freq_i,
    input  wire logic        multi_pump_i,
    input  wire logic        timer_one_start_i,
    input  wire logic        timer_two_start_i,
    input  wire logic        count_trigger_i,
    input  wire logic        count_clear_i,
    input  wire logic [11:0] analog_volt_i,
    input  wire logic [11:0] analog_curr_i,
    input  wire logic [11:0] aux_analog_in_a_i,
    input  wire logic [11:0] aux_analog_in_b_i,
    input  wire logic        reverse_cmd_i,
    input  wire logic        run_i,
    input  wire logic        up_i,
    input  wire logic        down_i,
    output logic             uniform_one_reach_o,
    output logic             uniform_two_reach_o,
    output logic             timer_one_reach_o,
    output logic             timer_two_reach_o,
    output logic             count_target_reach_o,
    output logic             count_mid_reach_o,
    output logic      [15:0] analog_freq_o,
    output logic             analog_reverse_o,
    output logic      [15:0] set_freq_o
);
    dat_pkg::dat_state_t st;
    dat_pkg::dat_state_t next_st;
    logic start1;
    logic start2;
    logic trig;
    logic clr_in;

    if (MS_CYC < 2 || MS_CYC > 65536 || PULSE_CYC < 1
            || PULSE_CYC > 65536) begin : g_chk
        $error("dat_top: timing parameter out of range");
    end

    function automatic logic [15:0] lim(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
        lim = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Rising threshold unless below is set, then falling threshold.
    function automatic logic hyst(input logic        prev,
                                  input logic [15:0] f,
                                  input logic [15:0] thr,
                                  input logic [15:0] rng,
                                  input logic        below);
        logic [16:0] fr;
        logic [16:0] tr;
        begin
            fr = {1'b0, f} + {1'b0, rng};
            tr = {1'b0, thr} + {1'b0, rng};
            if (below) begin
                hyst = prev ? ({1'b0, f} <= tr) : (f < thr);
            end else begin
                hyst = prev ? (fr >= {1'b0, thr}) : (f > thr);
            end
        end
    endfunction

    function automatic logic [11:0] avg(input logic [11:0] a,
                                        input logic [11:0] b);
        logic [12:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            avg = s[12:1];
        end
    endfunction

    // Full scale 4095 is stretched to 4096 so a shift replaces a divide.
    function automatic logic [12:0] fs(input logic [11:0] x);
        fs = {1'b0, x} + {12'h000, x[11]};
    endfunction

    function automatic logic [11:0] srcmux(input logic [3:0]  code,
                                           input logic [11:0] v,
                                           input logic [11:0] i,
                                           input logic [11:0] a,
                                           input logic [11:0] b);
        logic [13:0] t;
        begin
            t = 14'h0000;
            unique case (dat_pkg::dat_src_t'(code))
                dat_pkg::SRC_V10:   srcmux = v;
                dat_pkg::SRC_V5:    srcmux = v[11] ? 12'hFFF : {v[10:0], 1'b0};
                dat_pkg::SRC_I20:   srcmux = i;
                dat_pkg::SRC_I4: begin
                    t = (i < `DAT_I4MA) ? 14'h0000
                        : 14'((i - `DAT_I4MA) * 14'h0005 >> 2);
                    srcmux = t[13:12] != 2'b00 ? 12'hFFF : t[11:0];
                end
                dat_pkg::SRC_STACK: srcmux = avg(v, i);
                dat_pkg::SRC_A:     srcmux = a;
                dat_pkg::SRC_VA2:   srcmux = avg(v, a);
                dat_pkg::SRC_VA4: begin
                    t = {1'b0, v, 1'b0} + {2'b00, v} + {2'b00, a};
                    srcmux = t[13:2];
                end
                dat_pkg::SRC_AB2:   srcmux = avg(a, b);
                dat_pkg::SRC_MAX:   srcmux = (a > b) ? a : b;
                dat_pkg::SRC_MIN:   srcmux = (a < b) ? a : b;
                default:            srcmux = 12'h000;
            endcase
        end
    endfunction

    dat_qual #(.CYC(1)) u_start1 (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .in_i    (timer_one_start_i),
        .level_o (start1)
    );
    dat_qual #(.CYC(1)) u_start2 (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .in_i    (timer_two_start_i),
        .level_o (start2)
    );
    dat_qual #(.CYC(PULSE_CYC)) u_trig (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .in_i    (count_trigger_i),
        .level_o (trig)
    );
    dat_qual #(.CYC(PULSE_CYC)) u_clr (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .in_i    (count_clear_i),
        .level_o (clr_in)
    );

    always_comb begin
        logic               req;
        logic               ms;
        logic               tick;
        logic [15:0]        wv;
        logic [10:0]        tg1;
        logic [10:0]        tg2;
        logic               cclr;
        logic [11:0]        x;
        logic signed [12:0] d;
        logic signed [17:0] los;
        logic signed [17:0] his;
        logic signed [31:0] prod;
        logic signed [17:0] f;
        logic [31:0]        sp;
        logic signed [17:0] ns;
        logic signed [17:0] stp;
        logic signed [17:0] mn;
        req = avs_read_i | avs_write_i;
        ms = 1'b0;
        tick = 1'b0;
        wv = avs_writedata_i[15:0];
        tg1 = 11'h000;
        tg2 = 11'h000;
        cclr = 1'b0;
        x = 12'h000;
        d = 13'sh0000;
        los = 18'sh0_0000;
        his = 18'sh0_0000;
        prod = 32'sh0000_0000;
        f = 18'sh0_0000;
        sp = 32'h0000_0000;
        ns = 18'sh0_0000;
        stp = 18'sh0_0000;
        mn = 18'sh0_0000;
        next_st = st;
        next_st.clr = 1'b0;

        // Two-phase slave: read data are loaded while waitrequest is
        // high, and a write lands only at the edge the master samples.
        if (req && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = 32'h0000_0000;
            if (avs_read_i && avs_address_i < 5'(`DAT_NREG)) begin
                next_st.rdata = {16'h0000, st.cfg[avs_address_i]};
            end else if (avs_read_i && avs_address_i == `DAT_IX_STATUS) begin
                next_st.rdata = {9'h000, st.arev, st.r2, st.r1, st.t2,
                                 st.t1, st.mid, st.tgt, st.count};
            end
        end else if (req) begin
            next_st.waitreq = 1'b1;
            if (avs_write_i) begin
                unique case (avs_address_i)
                    `DAT_IX_UF1, `DAT_IX_UF2, `DAT_IX_LOF, `DAT_IX_HIF,
                    `DAT_IX_MAIN:
                        next_st.cfg[avs_address_i] =
                            lim(wv, 16'h0000, `DAT_FREQ_MAX);
                    `DAT_IX_RANGE:
                        next_st.cfg[avs_address_i] =
                            lim(wv, 16'h0000, `DAT_RANGE_MAX);
                    `DAT_IX_T1:
                        next_st.cfg[avs_address_i] =
                            lim(wv, `DAT_T1_MIN, `DAT_T1_MAX);
                    `DAT_IX_T2:
                        next_st.cfg[avs_address_i] =
                            lim(wv, `DAT_T2_MIN, `DAT_T2_MAX);
                    `DAT_IX_CTGT, `DAT_IX_CMID:
                        next_st.cfg[avs_address_i] =
                            lim(wv, 16'h0000, `DAT_CNT_SET);
                    `DAT_IX_SRC:
                        next_st.cfg[avs_address_i] =
                            lim(wv, 16'h0000, `DAT_SRC_MAX);
                    `DAT_IX_FILT:
                        next_st.cfg[avs_address_i] =
                            lim(wv, 16'h0000, `DAT_FILT_MAX);
                    `DAT_IX_LOD, `DAT_IX_HID, `DAT_IX_NEGREV,
                    `DAT_IX_RETAIN, `DAT_IX_STEP:
                        next_st.cfg[avs_address_i] = {15'h0000, wv[0]};
                    `DAT_IX_PROG:
                        next_st.cfg[avs_address_i] = wv;
                    `DAT_IX_CTRL:
                        next_st.clr = avs_writedata_i[`DAT_CTRL_CLR];
                    default: ;
                endcase
            end
        end

        // Millisecond and 100 ms enables from one free divider.
        if (st.ms_c == 16'(MS_CYC - 1)) begin
            next_st.ms_c = 16'h0000;
            ms = 1'b1;
        end else begin
            next_st.ms_c = st.ms_c + 16'h0001;
        end
        if (ms) begin
            next_st.tick_c = (st.tick_c == `DAT_TICK_MS - 7'h01)
                             ? 7'h00 : st.tick_c + 7'h01;
            tick = (st.tick_c == `DAT_TICK_MS - 7'h01);
        end

        // The first 100 ms step may come early: the divider runs free.
        tg1 = st.cfg[`DAT_IX_T1][10:0];
        tg2 = 11'(st.cfg[`DAT_IX_T2][6:0] * `DAT_T2_SCALE);
        next_st.el1 = !start1 ? 11'h000
                      : (tick && st.el1 < tg1) ? st.el1 + 11'h001 : st.el1;
        next_st.el2 = !start2 ? 11'h000
                      : (tick && st.el2 < tg2) ? st.el2 + 11'h001 : st.el2;
        next_st.t1 = start1 && next_st.el1 >= tg1;
        next_st.t2 = start2 && next_st.el2 >= tg2;

        // Clear wins over a trigger edge in the same cycle.
        cclr = st.clr || clr_in;
        next_st.trig_q = trig;
        if (cclr) begin
            next_st.count = 16'h0000;
        end else if (trig && !st.trig_q && !st.tgt
                     && st.count != `DAT_CNT_SAT) begin
            next_st.count = st.count + 16'h0001;
        end
        next_st.tgt = next_st.count == st.cfg[`DAT_IX_CTGT];
        next_st.mid = next_st.count >= st.cfg[`DAT_IX_CMID];

        next_st.r1 = hyst(st.r1, out_freq_i, st.cfg[`DAT_IX_UF1],
                          st.cfg[`DAT_IX_RANGE], 1'b0);
        next_st.r2 = hyst(st.r2, out_freq_i, st.cfg[`DAT_IX_UF2],
                          st.cfg[`DAT_IX_RANGE], multi_pump_i);

        x = srcmux(st.cfg[`DAT_IX_SRC][3:0], analog_volt_i, analog_curr_i,
                   aux_analog_in_a_i, aux_analog_in_b_i);
        if (ms) begin
            if ({10'h000, st.fc} >= st.cfg[`DAT_IX_FILT]) begin
                next_st.fc = 6'h00;
                d = $signed({1'b0, x}) - $signed({1'b0, st.y});
                next_st.y = 12'(st.y + 12'(d >>> 2));
                if (d > -13'sd4 && d < 13'sd4) begin
                    next_st.y = x;
                end
            end else begin
                next_st.fc = st.fc + 6'h01;
            end
        end

        if (st.cfg[`DAT_IX_SRC] == 16'(dat_pkg::SRC_STACK)) begin
            sp = (`DAT_STACK_FREQ * {19'h0_0000, fs(st.y)}) >> 12;
            f = $signed({2'b00, sp[15:0]});
        end else begin
            los = $signed({2'b00, st.cfg[`DAT_IX_LOF]});
            his = $signed({2'b00, st.cfg[`DAT_IX_HIF]});
            los = st.cfg[`DAT_IX_LOD][0] ? -los : los;
            his = st.cfg[`DAT_IX_HID][0] ? -his : his;
            prod = (his - los) * $signed({1'b0, fs(st.y)});
            f = los + 18'(prod >>> 12);
        end
        if (f < 18'sh0_0000 && !st.cfg[`DAT_IX_NEGREV][0]) begin
            f = 18'sh0_0000;
        end
        next_st.af = f < 18'sh0_0000 ? 16'(-f) : f[15:0];
        next_st.arev = (f < 18'sh0_0000) ^ reverse_cmd_i;

        // The main setting register is never touched here, only offset.
        mn = $signed({2'b00, st.cfg[`DAT_IX_MAIN]});
        stp = st.cfg[`DAT_IX_STEP][0] ? `DAT_STEP_COARSE
                                      : `DAT_STEP_FINE;
        next_st.run_q = run_i;
        ns = mn + st.off;
        if (run_i && up_i && !down_i) begin
            ns = ns + stp;
        end else if (run_i && down_i && !up_i) begin
            ns = ns - stp;
        end
        if (ns < 18'sh0_0000) begin
            ns = 18'sh0_0000;
        end else if (ns > $signed({2'b00, `DAT_FREQ_MAX})) begin
            ns = $signed({2'b00, `DAT_FREQ_MAX});
        end
        next_st.off = ns - mn;
        if (st.run_q && !run_i && !st.cfg[`DAT_IX_RETAIN][0]) begin
            next_st.off = 18'sh0_0000;
            ns = mn;
        end
        next_st.sf = ns[15:0];
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.waitreq <= 1'b1;
            st.cfg[`DAT_IX_RANGE] <= `DAT_RST_RANGE;
            st.cfg[`DAT_IX_T1] <= `DAT_RST_T1;
            st.cfg[`DAT_IX_FILT] <= `DAT_RST_FILT;
            st.cfg[`DAT_IX_HIF] <= `DAT_RST_HIF;
            st.tgt <= 1'b1;
            st.mid <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata_o = st.rdata;
    assign avs_waitrequest_o = st.waitreq;
    assign uniform_one_reach_o = st.r1;
    assign uniform_two_reach_o = st.r2;
    assign timer_one_reach_o = st.t1;
    assign timer_two_reach_o = st.t2;
    assign count_target_reach_o = st.tgt;
    assign count_mid_reach_o = st.mid;
    assign analog_freq_o = st.af;
    assign analog_reverse_o = st.arev;
    assign set_freq_o = st.sf;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_req_taken;
        (avs_read_i || avs_write_i) && st.waitreq;
    endsequence
    sequence s_answer;
        !st.waitreq ##1 st.waitreq;
    endsequence
    a_bus_answer: assert property (s_req_taken |=> s_answer)
        else $error("waitrequest did not drop for exactly one cycle");

    a_count_sat: assert property (
        st.count == `DAT_CNT_SAT && !st.clr && !clr_in
        |=> st.count == `DAT_CNT_SAT)
        else $error("counter moved past saturation");
    a_count_hold: assert property (
        st.tgt && !st.clr && !clr_in |=> $stable(st.count))
        else $error("counter ran on after reaching the target");
    a_count_step: assert property (
        trig && !st.trig_q && !st.tgt && st.count != `DAT_CNT_SAT
        && !st.clr && !clr_in |=> st.count == $past(st.count) + 16'h0001)
        else $error("trigger edge did not add one");
    a_mid_reach: assert property (
        ##1 st.mid == (st.count >= $past(st.cfg[`DAT_IX_CMID])))
        else $error("intermediate flag wrong");
    a_tmr_clear: assert property (
        !start1 |=> !st.t1 && st.el1 == 11'h000)
        else $error("timer one not cleared on open start");
    a_tmr_reach: assert property (
        start1 && st.el1 >= st.cfg[`DAT_IX_T1][10:0] ##1 start1 |-> st.t1)
        else $error("timer one output missing after delay");
    a_uf_hyst: assert property (
        st.r1 && !$changed(st.cfg)
        && ({1'b0, out_freq_i} + {1'b0, st.cfg[`DAT_IX_RANGE]}
        >= {1'b0, st.cfg[`DAT_IX_UF1]}) |=> st.r1)
        else $error("uniform reach dropped inside the band");
    a_rev_forbid: assert property (
        ##1 !$past(st.cfg[`DAT_IX_NEGREV][0])
        |-> st.arev == $past(reverse_cmd_i))
        else $error("reverse commanded while forbidden");
    a_retain_off: assert property (
        st.run_q && !run_i && !st.cfg[`DAT_IX_RETAIN][0]
        |=> st.off == 18'sh0_0000)
        else $error("UP/DOWN change kept after stop");
endmodule
`default_nettype wire

//--- tb.sv
// Bench for the timer, counter, uniform-reach and UP/DOWN logic.
// Assumes shortened millisecond and pulse counts on the design.
`include "dat_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic        clock_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic [4:0]  avs_address_i = '0;
    logic [31:0] avs_writedata_i = '0, avs_readdata_o, q;
    logic [15:0] out_freq_i = '0, analog_freq_o, set_freq_o;
    logic [11:0] analog_volt_i = '0, analog_curr_i = '0;
    logic [11:0] aux_analog_in_a_i = '0, aux_analog_in_b_i = '0;
    logic        multi_pump_i = 0, timer_one_start_i = 0, timer_two_start_i = 0;
    logic        count_clear_i = 0, reverse_cmd_i = 0, run_i = 0, up_i = 0;
    logic        down_i = 0, count_trigger_i, avs_waitrequest_o;
    logic        uniform_one_reach_o, uniform_two_reach_o, timer_one_reach_o;
    logic        timer_two_reach_o, count_target_reach_o, count_mid_reach_o;
    logic        analog_reverse_o;
    int          n_fail = 0, n_tests = 0, i;
    always #50 clock_i = ~clock_i;
    dat_sw sw (.clock_i, .trig_o(count_trigger_i));
    dat_top #(.MS_CYC(10), .PULSE_CYC(20)) uut (.clock_i, .rst_n_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_readdata_o, .avs_waitrequest_o, .out_freq_i, .multi_pump_i,
        .timer_one_start_i, .timer_two_start_i, .count_trigger_i,
        .count_clear_i, .analog_volt_i, .analog_curr_i, .aux_analog_in_a_i,
        .aux_analog_in_b_i, .reverse_cmd_i, .run_i, .up_i, .down_i,
        .uniform_one_reach_o, .uniform_two_reach_o, .timer_one_reach_o,
        .timer_two_reach_o, .count_target_reach_o, .count_mid_reach_o,
        .analog_freq_o, .analog_reverse_o, .set_freq_o);
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One idle edge after release keeps each strobe from two writes at once.
    task automatic acc(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int k;
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= d;
        k = 0;
        do begin @(posedge clock_i); k++; end
        while (avs_waitrequest_o !== 1'b0 && k < 50);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (k >= 50) begin n_fail++; end_of_test; end
        @(posedge clock_i);
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        acc(0, `DAT_IX_FILT, '0); `CHK(q, 32'h0000_0014)
        acc(0, `DAT_IX_HIF, '0); `CHK(q, 32'h0000_1388)
        acc(0, 5'h1F, '0); `CHK(q, 32'h0000_0000)
        $display("registers done");
        acc(1, `DAT_IX_CTGT, 32'h0000_0003);
        acc(1, `DAT_IX_CMID, 32'h0000_0002);
        sw.pulse(2);
        acc(0, `DAT_IX_STATUS, '0); `CHK(q[17:0], 18'h2_0002)
        sw.pulse(2);
        acc(0, `DAT_IX_STATUS, '0); `CHK(q[17:0], 18'h3_0003)
        `CHK(count_target_reach_o, 1'b1)
        acc(1, `DAT_IX_CTRL, 32'h0000_0001);
        acc(0, `DAT_IX_STATUS, '0); `CHK(q[17:0], 18'h0_0000)
        `CHK(count_mid_reach_o, 1'b0)
        sw.pulse(1);
        count_clear_i <= 1'b1;
        repeat (30) @(posedge clock_i);
        count_clear_i <= 1'b0;
        acc(0, `DAT_IX_STATUS, '0); `CHK(q[17:0], 18'h0_0000)
        $display("counter done");
        acc(1, `DAT_IX_T1, 32'h0000_0002);
        acc(1, `DAT_IX_T2, 32'h0000_0001);
        timer_one_start_i <= 1'b1;
        timer_two_start_i <= 1'b1;
        repeat (900) @(posedge clock_i);
        `CHK(timer_one_reach_o, 1'b0)
        for (i = 0; i < 2500 && timer_one_reach_o !== 1'b1; i++)
            @(posedge clock_i);
        `CHK(timer_one_reach_o, 1'b1)
        if (i >= 2500) end_of_test;
        `CHK(timer_two_reach_o, 1'b0)
        for (i = 0; i < 12000 && timer_two_reach_o !== 1'b1; i++)
            @(posedge clock_i);
        `CHK(timer_two_reach_o, 1'b1)
        if (i >= 12000) end_of_test;
        timer_one_start_i <= 1'b0;
        timer_two_start_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        `CHK(timer_one_reach_o, 1'b0)
        `CHK(timer_two_reach_o, 1'b0)
        $display("timer done");
        acc(1, `DAT_IX_UF1, 32'h0000_03E8);
        out_freq_i <= 16'h044C;
        repeat (5) @(posedge clock_i);
        `CHK(uniform_one_reach_o, 1'b1)
        out_freq_i <= 16'h0384;
        repeat (5) @(posedge clock_i);
        `CHK(uniform_one_reach_o, 1'b0)
        acc(1, `DAT_IX_UF2, 32'h0000_03E8);
        multi_pump_i <= 1'b1;
        out_freq_i <= 16'h044C;
        repeat (3) @(posedge clock_i);
        `CHK(uniform_two_reach_o, 1'b0)
        out_freq_i <= 16'h0384;
        repeat (3) @(posedge clock_i);
        `CHK(uniform_two_reach_o, 1'b1)
        acc(1, `DAT_IX_MAIN, 32'h0000_03E8);
        acc(1, `DAT_IX_STEP, 32'h0000_0001);
        run_i <= 1'b1;
        up_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        up_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK(set_freq_o, 16'h0406)
        run_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK(set_freq_o, 16'h03E8)
        acc(1, `DAT_IX_RETAIN, 32'h0000_0001);
        run_i <= 1'b1;
        up_i <= 1'b1;
        @(posedge clock_i);
        up_i <= 1'b0;
        run_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        `CHK(set_freq_o, 16'h03F2)
        acc(1, `DAT_IX_FILT, '0);
        analog_volt_i <= 12'hFFF;
        repeat (600) @(posedge clock_i);
        `CHK(analog_freq_o, 16'h1388)
        acc(1, `DAT_IX_HID, 32'h0000_0001);
        @(posedge clock_i);
        `CHK(analog_freq_o, 16'h0000)
        acc(1, `DAT_IX_NEGREV, 32'h0000_0001);
        reverse_cmd_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        `CHK(analog_freq_o, 16'h1388)
        `CHK(analog_reverse_o, 1'b0)
        acc(1, `DAT_IX_SRC, 32'h0000_0004);
        repeat (600) @(posedge clock_i);
        `CHK(analog_freq_o, 16'h09C2)
        `CHK(analog_reverse_o, 1'b1)
        $display("frequency done");
        end_of_test;
    end
endmodule
`default_nettype wire
